// *** shared/itm_pkg.sv ***
// Constants and types shared by the 16-bit interval timer files
`default_nettype none

package itm_pkg;

  // Register byte addresses on the bus
  localparam logic [31:0] ITM_CTRL_OFS = 32'hfffff690;
  localparam logic [31:0] ITM_CMP_OFS = 32'hfffff694;
  localparam logic [31:0] ITM_STAT_OFS = 32'hfffff698;
  localparam logic [31:0] ITM_MASK_OFS = 32'hfffff69c;

  // Control register layout and reset
  localparam logic [7:0] ITM_CTRL_RST = 8'h00;
  localparam logic [7:0] ITM_CTRL_WMASK = 8'h87;
  localparam int ITM_RUN_BIT = 7;
  localparam int ITM_CKS_LSB = 0;

  // Compare register and counter values
  localparam logic [15:0] ITM_CMP_RST = 16'h0000;
  localparam logic [15:0] ITM_CNT_IDLE = 16'hffff;
  localparam logic [15:0] ITM_CNT_ZERO = 16'h0000;

  // Status and mask layout
  localparam int ITM_ST_MATCH_BIT = 0;
  localparam int ITM_ST_RUN_BIT = 1;
  localparam logic [31:0] ITM_RD_NONE = 32'h00000000;

  // Prescaler taps of the peripheral clock
  localparam int ITM_PSC_W = 9;
  localparam logic [8:0] ITM_MSK_DIV1 = 9'h000;
  localparam logic [8:0] ITM_MSK_DIV2 = 9'h001;
  localparam logic [8:0] ITM_MSK_DIV4 = 9'h003;
  localparam logic [8:0] ITM_MSK_DIV64 = 9'h03f;
  localparam logic [8:0] ITM_MSK_DIV512 = 9'h1ff;
  localparam logic [2:0] ITM_OSC_LAST = 3'h7;

  typedef enum logic [2:0] {
    ITM_CK_FXX,
    ITM_CK_DIV2,
    ITM_CK_DIV4,
    ITM_CK_DIV64,
    ITM_CK_DIV512,
    ITM_CK_WATCH,
    ITM_CK_OSC8,
    ITM_CK_SUB
  } itm_cks_t;

  typedef enum logic {
    ITM_STOP,
    ITM_RUN
  } itm_st_t;

  typedef enum logic [2:0] {
    ITM_REG_CTRL,
    ITM_REG_CMP,
    ITM_REG_STAT,
    ITM_REG_MASK,
    ITM_REG_NONE
  } itm_reg_t;

endpackage

`default_nettype wire

// *** src/itm_clksel.sv ***
// Count clock source selection and prescaler of the interval timer
`timescale 1ns/1ps
`default_nettype none

module itm_clksel
  import itm_pkg::*;
#(
  parameter int PSC_W = ITM_PSC_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [2:0] cks_i,
  input wire logic watch_tick_i,
  input wire logic osc_i,
  input wire logic sub_i,
  output logic tick_o
);

  typedef struct packed {
    logic [PSC_W-1:0] psc;
    logic [2:0] osc_cnt;
    logic watch_q;
    logic osc_q;
    logic sub_q;
    logic tick;
  } itm_cs_t;

  itm_cs_t s;
  itm_cs_t n;

  function automatic logic [PSC_W-1:0] itm_tap(input itm_cks_t c);
    unique case (c)
      ITM_CK_DIV2: itm_tap = PSC_W'(ITM_MSK_DIV2);
      ITM_CK_DIV4: itm_tap = PSC_W'(ITM_MSK_DIV4);
      ITM_CK_DIV64: itm_tap = PSC_W'(ITM_MSK_DIV64);
      ITM_CK_DIV512: itm_tap = PSC_W'(ITM_MSK_DIV512);
      default: itm_tap = PSC_W'(ITM_MSK_DIV1);
    endcase
  endfunction

  always_comb begin
    n = s;
    n.tick = 1'b0;
    // Edge history follows the pins even when stopped, so no false edge at start
    n.watch_q = watch_tick_i;
    n.osc_q = osc_i;
    n.sub_q = sub_i;
    if (!run_i) begin
      n.psc = '0;
      n.osc_cnt = '0;
    end else begin
      n.psc = s.psc + 1'b1;
      unique case (itm_cks_t'(cks_i))
        ITM_CK_WATCH: n.tick = watch_tick_i & ~s.watch_q;
        ITM_CK_OSC8: begin
          if (osc_i & ~s.osc_q) begin
            n.osc_cnt = s.osc_cnt + 3'h1;
            n.tick = (s.osc_cnt == ITM_OSC_LAST);
          end
        end
        ITM_CK_SUB: n.tick = sub_i & ~s.sub_q;
        default: n.tick = (s.psc & itm_tap(itm_cks_t'(cks_i))) == itm_tap(itm_cks_t'(cks_i));
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick_o = s.tick;

endmodule

`default_nettype wire

// *** src/itm_timer.sv ***
// 16-bit interval timer with Wishbone register access and compare interrupt
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Operation
// - A 16-bit up-counter runs on the selected count clock and software cannot read or write it.
// - The compare register is 16 bits, read/write, written only as a whole word, reset to zero.
// - The control register is 8 bits, byte or bit writable, reset to zero.
// - With run enable low the count clock is held low and the counter is reset.
// - Clock select picks fxx, fxx/2, fxx/4, fxx/64, fxx/512, watch tick, oscillator/8 or subclock.
// - After enable the counter steps from all-ones to zero on a count clock and counts up.
// - On a match the next count clears the counter and raises the interrupt, period compare plus one.
// - A compare value of zero raises the interrupt every count clock with the counter held at zero.
// - Counting starts within the worst-case delay of the selected source after enable.
// - Only clear-and-start counting exists, no free-running mode.
module itm_timer
  import itm_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PSC_W = ITM_PSC_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic watch_tick_irq_i,
  input wire logic internal_osc_clock_i,
  input wire logic subclock_i,
  output logic compare_match_irq_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0] ctrl;
    logic [CNT_W-1:0] cmp;
    logic [CNT_W-1:0] cnt;
    itm_st_t st;
    logic ack;
    logic [31:0] rdat;
    logic stat;
    logic mask;
    logic irq;
    logic match;
  } itm_state_t;

  itm_state_t s;
  itm_state_t n;

  logic tick;
  logic run;
  logic req;
  logic wr;
  itm_reg_t rsel;
  logic lanes_ok;
  logic wr_ctrl;
  logic wr_cmp;
  logic wr_stat;
  logic wr_mask;
  logic clr_match;
  logic cnt_hit;
  logic [CNT_W-1:0] cnt_step;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic itm_reg_t itm_decode(input logic [31:0] adr);
    if (adr == ITM_CTRL_OFS) begin
      itm_decode = ITM_REG_CTRL;
    end else if (adr == ITM_CMP_OFS) begin
      itm_decode = ITM_REG_CMP;
    end else if (adr == ITM_STAT_OFS) begin
      itm_decode = ITM_REG_STAT;
    end else if (adr == ITM_MASK_OFS) begin
      itm_decode = ITM_REG_MASK;
    end else begin
      itm_decode = ITM_REG_NONE;
    end
  endfunction

  // Byte lanes a write needs; the compare takes whole 16-bit words only
  function automatic logic [3:0] itm_lane_need(input itm_reg_t r);
    logic [3:0] v;
    unique case (r)
      ITM_REG_CMP: begin
        v = 4'h3;
      end
      default: begin
        v = 4'h1;
      end
    endcase
    itm_lane_need = v;
  endfunction

  function automatic logic itm_lanes_ok(input logic [3:0] sel, input logic [3:0] need);
    itm_lanes_ok = ((sel & need) == need);
  endfunction

  // Unused control bits are not stored, so they always read back as zero
  function automatic logic [7:0] itm_ctrl_next(input logic [7:0] old, input logic [7:0] data, input logic lane);
    logic [7:0] v;
    v = old;
    if (lane) begin
      v = data & ITM_CTRL_WMASK;
    end
    itm_ctrl_next = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Read words

  function automatic logic [31:0] itm_ctrl_word(input logic [7:0] c);
    logic [31:0] v;
    v = ITM_RD_NONE;
    v[7:0] = c;
    itm_ctrl_word = v;
  endfunction

  function automatic logic [31:0] itm_cmp_word(input logic [CNT_W-1:0] c);
    logic [31:0] v;
    v = ITM_RD_NONE;
    v[CNT_W-1:0] = c;
    itm_cmp_word = v;
  endfunction

  // Sticky match flag plus the live run state
  function automatic logic [31:0] itm_status_word(input itm_state_t cur);
    logic [31:0] v;
    v = ITM_RD_NONE;
    v[ITM_ST_MATCH_BIT] = cur.stat;
    v[ITM_ST_RUN_BIT] = (cur.st == ITM_RUN);
    itm_status_word = v;
  endfunction

  function automatic logic [31:0] itm_mask_word(input logic m);
    logic [31:0] v;
    v = ITM_RD_NONE;
    v[ITM_ST_MATCH_BIT] = m;
    itm_mask_word = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Counter and interrupt helpers

  function automatic logic [CNT_W-1:0] itm_cnt_next(input logic [CNT_W-1:0] cnt, input logic hit);
    logic [CNT_W-1:0] v;
    if (hit) begin
      v = CNT_W'(ITM_CNT_ZERO);
    end else begin
      v = cnt + 1'b1;
    end
    itm_cnt_next = v;
  endfunction

  // Level request: any sticky source that software has let through
  function automatic logic itm_irq_level(input logic st, input logic m);
    itm_irq_level = st & m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register read

  function automatic logic [31:0] itm_read(input itm_reg_t r, input itm_state_t cur);
    logic [31:0] v;
    v = ITM_RD_NONE;
    unique case (r)
      ITM_REG_CTRL: begin
        v = itm_ctrl_word(cur.ctrl);
      end
      ITM_REG_CMP: begin
        v = itm_cmp_word(cur.cmp);
      end
      ITM_REG_STAT: begin
        v = itm_status_word(cur);
      end
      ITM_REG_MASK: begin
        v = itm_mask_word(cur.mask);
      end
      default: begin
        v = ITM_RD_NONE;
      end
    endcase
    itm_read = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Count clock source

  assign run = s.ctrl[ITM_RUN_BIT];

  itm_clksel #(
    .PSC_W(PSC_W)
  ) u_clksel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .cks_i(s.ctrl[ITM_CKS_LSB +: 3]),
    .watch_tick_i(watch_tick_irq_i),
    .osc_i(internal_osc_clock_i),
    .sub_i(subclock_i),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus request

  // One answer per request: the ack flop blocks a second take of the same cycle
  assign req = wb_cyc_i & wb_stb_i & ~s.ack;
  assign wr = req & wb_we_i;
  assign rsel = itm_decode(wb_adr_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Register write decode

  // A write short of lanes is still acked, but dropped
  assign lanes_ok = itm_lanes_ok(wb_sel_i, itm_lane_need(rsel));
  assign wr_ctrl = wr && (rsel == ITM_REG_CTRL) && lanes_ok;
  assign wr_cmp = wr && (rsel == ITM_REG_CMP) && lanes_ok;
  assign wr_stat = wr && (rsel == ITM_REG_STAT) && lanes_ok;
  assign wr_mask = wr && (rsel == ITM_REG_MASK) && lanes_ok;
  // Write one to clear; zeros leave the flag alone
  assign clr_match = wr_stat && wb_dat_i[ITM_ST_MATCH_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Compare

  assign cnt_hit = (s.cnt == s.cmp);

  assign cnt_step = itm_cnt_next(s.cnt, cnt_hit);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = s;
    n.ack = 1'b0;
    n.match = 1'b0;

    // Register reads answer one cycle after the request
    if (req) begin
      n.ack = 1'b1;
      n.rdat = itm_read(rsel, s);
    end

    n.ctrl = itm_ctrl_next(s.ctrl, wb_dat_i[7:0], wr_ctrl);

    if (wr_cmp) begin
      n.cmp = wb_dat_i[CNT_W-1:0];
    end

    if (wr_mask) begin
      n.mask = wb_dat_i[ITM_ST_MATCH_BIT];
    end

    if (clr_match) begin
      n.stat = 1'b0;
    end

    // Counter sequencing
    unique case (s.st)
      ITM_STOP: begin
        n.cnt = ITM_CNT_IDLE;
        if (run) begin
          n.st = ITM_RUN;
        end
      end
      ITM_RUN: begin
        if (!run) begin
          n.st = ITM_STOP;
          n.cnt = ITM_CNT_IDLE;
        end else if (tick) begin
          n.cnt = cnt_step;
          n.match = cnt_hit;
        end
      end
    endcase

    // A match in the clearing cycle keeps the flag set
    if (n.match) begin
      n.stat = 1'b1;
    end

    n.irq = itm_irq_level(n.stat, n.mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s.ctrl <= ITM_CTRL_RST;
      s.cmp <= ITM_CMP_RST;
      // Counter parks at all-ones so the first tick after enable lands on zero
      s.cnt <= ITM_CNT_IDLE;
      s.st <= ITM_STOP;
      s.ack <= 1'b0;
      s.rdat <= ITM_RD_NONE;
      s.stat <= 1'b0;
      s.mask <= 1'b0;
      s.irq <= 1'b0;
      s.match <= 1'b0;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Every output is a flop field; nothing reaches a pin from the bus combinationally
  assign wb_dat_o = s.rdat;
  assign wb_ack_o = s.ack;
  assign compare_match_irq_o = s.match;
  assign irq_o = s.irq;

endmodule

`default_nettype wire

// *** test/itm_timer_monitor.sv ***
// Port checker of the interval timer
`timescale 1ns/1ps
`default_nettype none
module itm_timer_monitor
  import itm_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PSC_W = ITM_PSC_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic watch_tick_irq_i,
  input wire logic internal_osc_clock_i,
  input wire logic subclock_i,
  input wire logic compare_match_irq_o,
  input wire logic irq_o
);
  logic tk, run_r, msk_r, unm_r;
  logic [1:0] stop_r;
  assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= 1'b0;
      msk_r <= 1'b0;
      unm_r <= 1'b0;
      stop_r <= 2'h0;
    end else begin
      if (tk && wb_we_i && wb_sel_i[0] && wb_adr_i == ITM_CTRL_OFS) begin
        run_r <= wb_dat_i[ITM_RUN_BIT];
      end
      if (tk && wb_we_i && wb_sel_i[0] && wb_adr_i == ITM_MASK_OFS) begin
        msk_r <= wb_dat_i[ITM_ST_MATCH_BIT];
      end
      unm_r <= tk && !wb_we_i && wb_adr_i[31:4] != 28'hfffff69;
      // Saturates at 3: a pulse already in flight may still show for one cycle
      stop_r <= run_r ? 2'h0 : stop_r + {1'b0, stop_r != 2'h3};
    end
  end
////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_next:
    assert property (tk |=> wb_ack_o) else $error("request not answered");
  a_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause:
    assert property ($rose(wb_ack_o) |-> $past(tk)) else $error("ack without request");
  a_reset_quiet:
    assert property ($fell(rst_i) |-> !wb_ack_o && !compare_match_irq_o && !irq_o) else $error("busy after reset");
  a_unmapped_zero:
    assert property (wb_ack_o && unm_r |-> wb_dat_o == ITM_RD_NONE) else $error("unmapped read not zero");
  a_stopped_quiet:
    assert property (stop_r == 2'h3 |-> !compare_match_irq_o) else $error("pulse while stopped");
  a_irq_masked:
    assert property ($rose(irq_o) |-> msk_r || $past(msk_r)) else $error("irq while masked");
  a_irq_mask_off:
    assert property (!msk_r [*3] |-> !irq_o) else $error("irq kept after mask off");
  c_match: cover property (compare_match_irq_o);
  c_irq: cover property ($rose(irq_o));
  c_unmapped: cover property (wb_ack_o && unm_r);
endmodule
bind itm_timer itm_timer_monitor #(.CNT_W(CNT_W), .PSC_W(PSC_W)) mon_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .watch_tick_irq_i(watch_tick_irq_i),
  .internal_osc_clock_i(internal_osc_clock_i), .subclock_i(subclock_i),
  .compare_match_irq_o(compare_match_irq_o), .irq_o(irq_o));
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench of the interval timer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import itm_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, q;
  logic [3:0] wb_sel_i = '0;
  logic [7:0] ph = '0;
  logic wb_ack_o, compare_match_irq_o, irq_o;
  int failures = 0, checks_done = 0, t, k;
  always #2.5 clk_i = ~clk_i;
  // Slow sources: watch tick every 16, oscillator every 2, subclock every 8 cycles
  always @(posedge clk_i) ph <= ph + 8'h01;
  itm_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .watch_tick_irq_i(ph[3]), .internal_osc_clock_i(ph[0]), .subclock_i(ph[2]),
    .compare_match_irq_o(compare_match_irq_o), .irq_o(irq_o));
////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(nm, q, exp);
  endtask
  task automatic pw(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (compare_match_irq_o !== 1'b1);
  endtask
  function automatic int exp_gap(input int c, input int n);
    int per[8] = '{1, 2, 4, 64, 512, 16, 16, 8};
    return (n + 1) * per[c];
  endfunction
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    void'($urandom(15144));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("ctrl", ITM_CTRL_OFS, ITM_CTRL_RST);
    rd("cmp", ITM_CMP_OFS, ITM_CMP_RST);
    rd("unmapped", 32'hfffff6a0, ITM_RD_NONE);
    k = $urandom % 32'hffff;
    bus(1'b1, ITM_CMP_OFS, k, 4'hf);
    bus(1'b1, ITM_CMP_OFS, ~k, 4'h1);
    rd("cmp", ITM_CMP_OFS, k);
    bus(1'b1, ITM_CTRL_OFS, 32'h7e, 4'h1);
    rd("ctrl", ITM_CTRL_OFS, 32'h06);
    $display("register test ended");
    for (int c = 0; c < 8; c++) begin
      k = (c == 0) ? 0 : $urandom % 4;
      bus(1'b1, ITM_CTRL_OFS, 32'h0, 4'hf);
      bus(1'b1, ITM_CMP_OFS, k, 4'hf);
      bus(1'b1, ITM_CTRL_OFS, 32'h80 | c, 4'h1);
      pw(t);
      pw(t);
      chk("interval", t, exp_gap(c, k));
    end
    $display("interval test ended");
    chk("irq masked", irq_o, 1'b0);
    bus(1'b1, ITM_MASK_OFS, 32'h1, 4'hf);
    @(posedge clk_i);
    chk("irq", irq_o, 1'b1);
    rd("status", ITM_STAT_OFS, 32'h3);
    bus(1'b1, ITM_CTRL_OFS, 32'h0, 4'hf);
    repeat (3) @(posedge clk_i);
    k = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (compare_match_irq_o === 1'b1) k++;
    end
    chk("stopped", k, 0);
    bus(1'b1, ITM_STAT_OFS, 32'h1, 4'hf);
    rd("status", ITM_STAT_OFS, 32'h0);
    chk("irq cleared", irq_o, 1'b0);
    $display("interrupt test ended");
    close_out();
  end
  // Longest case is about 5000 cycles per source; allow ample margin
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
